// File: inc/clsc_pkg.sv
// Constants and types for the current limit and sequencing command bank
package clsc_pkg;
    // Command codes
    localparam logic [7:0] CMD_SLEW = 8'h27;
    localparam logic [7:0] CMD_GAIN = 8'h38;
    localparam logic [7:0] CMD_OCF  = 8'h46;
    localparam logic [7:0] CMD_OCW  = 8'h4a;
    localparam logic [7:0] CMD_TOND = 8'h60;
    localparam logic [7:0] CMD_TONR = 8'h61;
    localparam logic [7:0] CMD_TONM = 8'h62;
    localparam logic [7:0] CMD_TOFD = 8'h64;
    localparam logic [7:0] CMD_TOFF = 8'h65;
    localparam logic [7:0] CMD_TOFW = 8'h66;
    localparam logic [7:0] CMD_RST  = 8'hdc;
    localparam logic [7:0] CMD_EMU  = 8'hf7;
    localparam logic [7:0] CMD_SPI  = 8'he8;
    // Word register storage slots
    localparam int NREG = 11;
    localparam logic [3:0] IX_SLEW = 4'h0;
    localparam logic [3:0] IX_GAIN = 4'h1;
    localparam logic [3:0] IX_OCF  = 4'h2;
    localparam logic [3:0] IX_OCW  = 4'h3;
    localparam logic [3:0] IX_TOND = 4'h4;
    localparam logic [3:0] IX_TONR = 4'h5;
    localparam logic [3:0] IX_TONM = 4'h6;
    localparam logic [3:0] IX_TOFD = 4'h7;
    localparam logic [3:0] IX_TOFF = 4'h8;
    localparam logic [3:0] IX_TOFW = 4'h9;
    localparam logic [3:0] IX_RST  = 4'ha;
    // Reset values
    localparam logic [15:0] RV_SLEW = 16'h82bf;
    localparam logic [15:0] RV_GAIN = 16'hca80;
    localparam logic [15:0] RV_OCF  = 16'hdbb8;
    localparam logic [15:0] RV_OCW  = 16'hda80;
    localparam logic [15:0] RV_TOND = 16'h8000;
    localparam logic [15:0] RV_TONR = 16'hd200;
    localparam logic [15:0] RV_TONM = 16'hd280;
    localparam logic [15:0] RV_TOFD = 16'h8000;
    localparam logic [15:0] RV_TOFF = 16'hd200;
    localparam logic [15:0] RV_TOFW = 16'h8000;
    localparam logic [15:0] RV_RST  = 16'hfbe8;
    localparam logic [3:0]  RV_EMU  = 4'h0;
    // Emulation control fields
    localparam int EMU_W     = 4;
    localparam int EMU_MODE  = 2;
    localparam int EMU_TRIG  = 3;
    // Timing
    localparam int CLK_MHZ         = 250;
    localparam int MS_US           = 1000;
    localparam int MS_TICK_CYCLES  = CLK_MHZ * MS_US;
    localparam int LSE_PULSE_US    = 100;
    localparam int LSE_CYCLES      = LSE_PULSE_US * CLK_MHZ;
    localparam int CW              = 20;
    localparam int TON_DLY_MAX_MS  = 83000;
    localparam int RAMP_MAX_MS     = 1300;
    localparam int TON_MAX_MS      = 8000;
    localparam int TOFF_DLY_MAX_MS = 16000;
    localparam int TOFW_MIN_MS     = 120;
    localparam int TOFW_MAX_MS     = 524000;
    localparam int RST_MIN_MS      = 136;
    localparam int RST_MAX_MS      = 65520;
    localparam int RST_GRAN_MS     = 16;
    // Channel sequencer states
    typedef enum logic [5:0] {
        SQ_OFF  = 6'b00_0001,
        SQ_ONW  = 6'b00_0010,
        SQ_RISE = 6'b00_0100,
        SQ_ON   = 6'b00_1000,
        SQ_OFFW = 6'b01_0000,
        SQ_FALL = 6'b10_0000
    } clsc_seq_t;
endpackage : clsc_pkg

// File: logic/clsc_seq.sv
// Power-up and power-down sequencer for one master channel
`timescale 1ns/1ns
module clsc_seq (
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   srst,
    input  wire logic                   ms_tick,
    // Channel conditions
    input  wire logic                   run_in,
    input  wire logic                   op_on,
    input  wire logic                   above_uv,
    input  wire logic                   below_eighth,
    // Times in ms
    input  wire logic [clsc_pkg::CW-1:0] t_on_dly,
    input  wire logic [clsc_pkg::CW-1:0] t_rise,
    input  wire logic [clsc_pkg::CW-1:0] t_on_max,
    input  wire logic [clsc_pkg::CW-1:0] t_off_dly,
    input  wire logic [clsc_pkg::CW-1:0] t_fall,
    input  wire logic [clsc_pkg::CW-1:0] t_off_warn,
    input  wire logic [clsc_pkg::CW-1:0] t_restart,
    // Status
    output logic                        ramp_r,
    output logic                        on_r,
    output logic                        ton_fault_r,
    output logic                        toff_warn_r,
    output logic                        run_oe_n_r
);
    import clsc_pkg::*;
    typedef struct packed {
        clsc_seq_t     st;
        logic [CW-1:0] cnt, wcnt, hold;
        logic          run_q, uvok, wchk, ramp, on, tf, tw, oe_n;
    } clsc_sq_t;
    clsc_sq_t s, n;
    logic stop;

    always_comb begin
        n = s;
        stop = !(run_in && op_on);
        n.run_q = run_in;
        n.tf = 1'b0;
        n.tw = 1'b0;
        if (ms_tick && s.cnt != '0) n.cnt = s.cnt - 1'b1;
        if (ms_tick && s.wcnt != '0) n.wcnt = s.wcnt - 1'b1;
        // Own low drive would look like another edge, so only watch when released
        if (s.run_q && !run_in && s.oe_n) begin
            n.hold = t_restart;
            n.oe_n = 1'b0;
        end else if (!s.oe_n && ms_tick) begin
            // Release on the tick after zero, so never early
            if (s.hold == '0) n.oe_n = 1'b1;
            else n.hold = s.hold - 1'b1;
        end
        // Each wait ends on a tick: up to one ms long, never short
        case (s.st)
            SQ_OFF: begin
                if (s.wchk) begin
                    if (below_eighth) n.wchk = 1'b0;
                    else if (s.wcnt == '0 && ms_tick) begin
                        n.tw = 1'b1;
                        n.wchk = 1'b0;
                    end
                end
                if (!stop && s.oe_n) begin
                    n.st = SQ_ONW;
                    n.cnt = t_on_dly;
                end
            end
            SQ_ONW: begin
                if (stop) n.st = SQ_OFF;
                else if (s.cnt == '0 && ms_tick) begin
                    n.st = SQ_RISE;
                    n.cnt = t_rise;
                    n.wcnt = t_on_max;
                    n.uvok = 1'b0;
                end
            end
            SQ_RISE: if (s.cnt == '0 && ms_tick) n.st = SQ_ON;
            SQ_ON: ;
            SQ_OFFW: if (s.cnt == '0 && ms_tick) begin
                n.st = SQ_FALL;
                n.cnt = t_fall;
            end
            SQ_FALL: if (s.cnt == '0 && ms_tick) begin
                n.st = SQ_OFF;
                n.wcnt = t_off_warn;
                n.wchk = t_off_warn != '0;
            end
            default: n.st = SQ_OFF;
        endcase
        if ((s.st == SQ_RISE || s.st == SQ_ON) && !s.uvok) begin
            if (above_uv) n.uvok = 1'b1;
            else if (t_on_max != '0 && s.wcnt == '0 && ms_tick) begin
                n.tf = 1'b1;
                n.uvok = 1'b1;
            end
        end
        if ((s.st == SQ_RISE || s.st == SQ_ON) && stop) begin
            n.st = SQ_OFFW;
            n.cnt = t_off_dly;
        end
        n.ramp = n.st == SQ_RISE || n.st == SQ_FALL;
        n.on = n.st == SQ_ON;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s <= '0;
            s.st <= SQ_OFF;
            s.oe_n <= 1'b1;
        end else s <= n;
    end

    assign ramp_r = s.ramp;
    assign on_r = s.on;
    assign ton_fault_r = s.tf;
    assign toff_warn_r = s.tw;
    assign run_oe_n_r = s.oe_n;

    a_run_hold: assert property (@(posedge clock) disable iff (srst)
        (s.run_q && !run_in && s.oe_n) |=> !run_oe_n_r)
        else $error("run pin not held low after falling edge");
    a_no_start: assert property (@(posedge clock) disable iff (srst)
        (!s.oe_n && s.st == SQ_OFF) |=> s.st == SQ_OFF)
        else $error("start-up began during restart hold");
endmodule : clsc_seq

// File: logic/clsc_bank.sv
// Per-channel current limit, load emulation and sequencing command bank
`timescale 1ns/1ns
module clsc_bank #(
    parameter int MS_CYCLES  = clsc_pkg::MS_TICK_CYCLES,
    parameter int LSE_PULSE  = clsc_pkg::LSE_CYCLES
) (
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  srst,
    // Command port
    input  wire logic                  cmd_wr,
    input  wire logic                  cmd_rd,
    input  wire logic                  cmd_page,
    input  wire logic [7:0]            cmd_code,
    input  wire logic [15:0]           cmd_wdata,
    output logic      [15:0]           rd_data_r,
    output logic                       rd_valid_r,
    output logic                       cml_fault_r,
    // Channel inputs
    input  wire logic [1:0]            run_pin_i,
    input  wire logic [1:0]            op_on,
    input  wire logic [1:0]            power_good_signal,
    input  wire logic [1:0][15:0]      sense_diff_mv,
    input  wire logic [1:0][15:0]      iout_avg_a,
    input  wire logic [1:0]            vout_above_uv,
    input  wire logic [1:0]            vout_below_eighth,
    input  wire logic [1:0][7:0]       serial_offset_code,
    // Channel outputs
    output logic      [1:0]            run_pin_o,
    output logic      [1:0]            run_pin_oe_n,
    output logic      [1:0][1:0]       emulated_load_step_r,
    output logic      [1:0]            scope_trig_r,
    output logic      [1:0]            oc_fault_r,
    output logic      [1:0]            oc_warn_r,
    output logic      [1:0]            ramping_r,
    output logic      [1:0]            regulating_r,
    output logic      [1:0]            ton_fault_r,
    output logic      [1:0]            toff_warn_r,
    output logic      [1:0][15:0]      slew_rate_r
);
    import clsc_pkg::*;

    localparam int MSW = $clog2(MS_CYCLES + 1);
    localparam int PW  = $clog2(LSE_PULSE + 1);

    if (MS_CYCLES < 1 || LSE_PULSE < 1) begin : g_chk
        $error("clsc_bank: cycle counts must be at least one");
    end

    typedef struct packed {
        logic [1:0][NREG-1:0][15:0] regs;
        logic [1:0][EMU_W-1:0]      emu;
        logic [1:0][PW-1:0]         lse_cnt;
        logic [1:0][1:0]            emulated_load_step;
        logic [1:0]                 pg_q, trig, ocf, ocw;
        logic [MSW-1:0]             tick_cnt;
        logic                       tick, rvalid, comm_memory_logic_fault;
        logic [15:0]                rdata;
    } clsc_st_t;

    clsc_st_t s, n;
    logic [4:0]          hit;
    logic [1:0]          off_cmd;
    logic [1:0]          ramp;
    logic [1:0][CW-1:0]  t_on_dly, t_rise, t_on_max, t_off_dly;
    logic [1:0][CW-1:0]  t_fall, t_off_warn, t_restart;
    logic [1:0][39:0]    oc_thr;

    // Code to storage slot, bit 4 marks a hit
    function automatic logic [4:0] reg_idx(input logic [7:0] code);
        case (code)
            CMD_SLEW: reg_idx = {1'b1, IX_SLEW};
            CMD_GAIN: reg_idx = {1'b1, IX_GAIN};
            CMD_OCF:  reg_idx = {1'b1, IX_OCF};
            CMD_OCW:  reg_idx = {1'b1, IX_OCW};
            CMD_TOND: reg_idx = {1'b1, IX_TOND};
            CMD_TONR: reg_idx = {1'b1, IX_TONR};
            CMD_TONM: reg_idx = {1'b1, IX_TONM};
            CMD_TOFD: reg_idx = {1'b1, IX_TOFD};
            CMD_TOFF: reg_idx = {1'b1, IX_TOFF};
            CMD_TOFW: reg_idx = {1'b1, IX_TOFW};
            CMD_RST:  reg_idx = {1'b1, IX_RST};
            default:  reg_idx = 5'h00;
        endcase
    endfunction : reg_idx

    // Five-bit exponent, eleven-bit mantissa to whole units, fraction dropped
    function automatic logic [CW-1:0] l11(input logic [15:0] v);
        logic [CW+15:0] w;
        logic [5:0]     ne;
        w = {{(CW+5){1'b0}}, v[10:0]};
        ne = 6'h00 - {v[15], v[15:11]};
        if (v[10]) return '0;
        if (v[15]) w = w >> ne;
        else w = w << v[14:11];
        if (|w[CW+15:CW]) return '1;
        return w[CW-1:0];
    endfunction : l11

    function automatic logic [CW-1:0] lim(input logic [CW-1:0] x,
                                          input int lo, input int hi);
        if (x < CW'(lo)) return CW'(lo);
        if (x > CW'(hi)) return CW'(hi);
        return x;
    endfunction : lim

    for (genvar c = 0; c < 2; c++) begin : g_ch
        logic [CW-1:0] rs;
        assign t_on_dly[c]  = lim(l11(s.regs[c][IX_TOND]), 0,
                                  TON_DLY_MAX_MS);
        assign t_rise[c]    = lim(l11(s.regs[c][IX_TONR]), 0, RAMP_MAX_MS);
        assign t_on_max[c]  = lim(l11(s.regs[c][IX_TONM]), 0, TON_MAX_MS);
        assign t_off_dly[c] = lim(l11(s.regs[c][IX_TOFD]), 0,
                                  TOFF_DLY_MAX_MS);
        assign t_fall[c]    = lim(l11(s.regs[c][IX_TOFF]), 0, RAMP_MAX_MS);
        // The reset value RV_TOFW disables the check, other values are held to the valid span
        assign t_off_warn[c] = s.regs[c][IX_TOFW] == RV_TOFW ? '0 :
            lim(l11(s.regs[c][IX_TOFW]), TOFW_MIN_MS, TOFW_MAX_MS);
        assign rs = lim(l11(s.regs[c][IX_RST]), RST_MIN_MS, RST_MAX_MS);
        // Rounded up so the pin is never released early
        assign t_restart[c] = CW'((rs + CW'(RST_GRAN_MS - 1))
                                  / CW'(RST_GRAN_MS)
                                  * CW'(RST_GRAN_MS));
        // Amps times milliohms gives the sense millivolts at the limit
        assign oc_thr[c] = l11(s.regs[c][IX_OCF])
                           * l11(s.regs[c][IX_GAIN]);
        assign off_cmd[c] = !(run_pin_i[c] && op_on[c]);

        clsc_seq u_seq (
            .clock        (clock),
            .srst         (srst),
            .ms_tick      (s.tick),
            .run_in       (run_pin_i[c]),
            .op_on        (op_on[c]),
            .above_uv     (vout_above_uv[c]),
            .below_eighth (vout_below_eighth[c]),
            .t_on_dly     (t_on_dly[c]),
            .t_rise       (t_rise[c]),
            .t_on_max     (t_on_max[c]),
            .t_off_dly    (t_off_dly[c]),
            .t_fall       (t_fall[c]),
            .t_off_warn   (t_off_warn[c]),
            .t_restart    (t_restart[c]),
            .ramp_r       (ramp[c]),
            .on_r         (regulating_r[c]),
            .ton_fault_r  (ton_fault_r[c]),
            .toff_warn_r  (toff_warn_r[c]),
            .run_oe_n_r   (run_pin_oe_n[c])
        );
    end

    always_comb begin
        hit = reg_idx(cmd_code);
        n = s;
        n.rvalid = 1'b0;
        n.comm_memory_logic_fault = 1'b0;
        n.pg_q = power_good_signal;
        n.tick = 1'b0;
        if (s.tick_cnt == MSW'(MS_CYCLES - 1)) begin
            n.tick_cnt = '0;
            n.tick = 1'b1;
        end else n.tick_cnt = s.tick_cnt + 1'b1;
        if (cmd_rd) begin
            n.rvalid = 1'b1;
            n.rdata = 16'h0000;
            if (hit[4]) n.rdata = s.regs[cmd_page][hit[3:0]];
            else if (cmd_code == CMD_EMU)
                n.rdata = {12'h000, s.emu[cmd_page]};
            else if (cmd_code == CMD_SPI)
                n.rdata = {8'h00, serial_offset_code[cmd_page]};
            else n.comm_memory_logic_fault = 1'b1;
        end
        if (cmd_wr) begin
            // Gain only changes with both rails commanded off
            if (cmd_code == CMD_GAIN && !(&off_cmd)) n.comm_memory_logic_fault = 1'b1;
            else if (hit[4]) n.regs[cmd_page][hit[3:0]] = cmd_wdata;
            else if (cmd_code == CMD_EMU)
                n.emu[cmd_page] = cmd_wdata[EMU_W-1:0];
            else n.comm_memory_logic_fault = 1'b1;
        end
        for (int c = 0; c < 2; c++) begin
            // One level per channel, shared by all of its phases
            if (!n.emu[c][EMU_MODE]) begin
                n.emulated_load_step[c] = n.emu[c][1:0];
                n.lse_cnt[c] = '0;
            end else if (cmd_wr && cmd_page == 1'(c) && cmd_code == CMD_EMU
                         && cmd_wdata[1:0] != 2'b00) begin
                n.emulated_load_step[c] = cmd_wdata[1:0];
                n.lse_cnt[c] = PW'(LSE_PULSE - 1);
            end else if (s.lse_cnt[c] != '0) begin
                n.lse_cnt[c] = s.lse_cnt[c] - 1'b1;
            end else n.emulated_load_step[c] = 2'b00;
            n.trig[c] = s.emu[c][EMU_TRIG] && s.pg_q[c]
                        && !power_good_signal[c];
            n.ocf[c] = !ramp[c] && regulating_r[c]
                       && {24'h00_0000, sense_diff_mv[c]} > oc_thr[c];
            n.ocw[c] = !ramp[c] && CW'(iout_avg_a[c])
                       > l11(s.regs[c][IX_OCW]);
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s <= '0;
            for (int c = 0; c < 2; c++) begin
                s.regs[c] <= {RV_RST, RV_TOFW, RV_TOFF, RV_TOFD, RV_TONM,
                              RV_TONR, RV_TOND, RV_OCW, RV_OCF, RV_GAIN,
                              RV_SLEW};
                s.emu[c] <= RV_EMU;
            end
        end else s <= n;
    end

    assign rd_data_r = s.rdata;
    assign rd_valid_r = s.rvalid;
    assign cml_fault_r = s.comm_memory_logic_fault;
    assign run_pin_o = 2'b00;
    assign emulated_load_step_r = s.emulated_load_step;
    assign scope_trig_r = s.trig;
    assign oc_fault_r = s.ocf;
    assign oc_warn_r = s.ocw;
    assign ramping_r = ramp;
    assign slew_rate_r = {s.regs[1][IX_SLEW], s.regs[0][IX_SLEW]};

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    sequence s_pulse_wr;
        cmd_wr && !cmd_page && cmd_code == CMD_EMU && cmd_wdata[EMU_MODE]
        && cmd_wdata[1:0] != 2'b00;
    endsequence
    sequence s_pulse_on;
        emulated_load_step_r[0] != 2'b00 && s.lse_cnt[0] != '0;
    endsequence

    a_lse_static: assert property (!s.emu[0][EMU_MODE] |->
        emulated_load_step_r[0] == s.emu[0][1:0])
        else $error("static emulation level does not follow control");
    a_lse_pulse: assert property (s_pulse_wr |=> s_pulse_on
        ##0 emulated_load_step_r[0] == $past(cmd_wdata[1:0]))
        else $error("emulation pulse not started by write");
    a_emu_rsvd: assert property ((cmd_rd && cmd_code == CMD_EMU) |=>
        rd_data_r[15:4] == 12'h000)
        else $error("reserved emulation bits read non-zero");
    a_trig_edge: assert property (scope_trig_r[0] |->
        $past(power_good_signal[0], 2) && !$past(power_good_signal[0]))
        else $error("scope trigger without power good fall");
    a_gain_cml: assert property ((cmd_wr && cmd_code == CMD_GAIN
        && run_pin_i[0] && op_on[0]) |=> cml_fault_r)
        else $error("gain write while on not flagged");
    a_ocf_ramp: assert property (ramping_r[0] |=> !oc_fault_r[0])
        else $error("overcurrent fault while ramping");
    a_ocw_ramp: assert property (ramping_r[0] |=> !oc_warn_r[0])
        else $error("overcurrent warning while ramping");
    a_ocw_set: assert property ((!ramping_r[0] && CW'(iout_avg_a[0])
        > l11(s.regs[0][IX_OCW])) |=> oc_warn_r[0])
        else $error("overcurrent warning missed");
    a_spi_read: assert property ((cmd_rd && cmd_code == CMD_SPI) |=>
        rd_valid_r && rd_data_r == {8'h00, ($past(cmd_page) ?
        $past(serial_offset_code[1]) : $past(serial_offset_code[0]))})
        else $error("offset code read back wrong");
endmodule : clsc_bank

// File: verification/clsc_stage_model.sv
// Power stage and comparator model for both channels
`timescale 1ns/1ns
module clsc_stage_model (
    // Clock
    input  wire logic       clock,
    // Sequencer state
    input  wire logic [1:0] ramping,
    input  wire logic [1:0] regulating,
    input  wire logic [1:0] stuck,
    // Comparator levels
    output logic      [1:0] above_uv,
    output logic      [1:0] below_eighth,
    output logic      [1:0] power_good
);
    initial begin
        above_uv = 2'b00;
        below_eighth = 2'b00;
        power_good = 2'b00;
    end
    // A stuck channel never rises, so the timeout path stays reachable
    always @(posedge clock) begin
        above_uv     <= regulating & ~stuck;
        below_eighth <= ~(ramping | regulating) & ~stuck;
        power_good   <= regulating & ~stuck;
    end
endmodule : clsc_stage_model

// File: verification/clsc_bank_tb.sv
// Self-checking bench for the command bank and channel sequencers
`timescale 1ns/1ns
module clsc_bank_tb;
    import clsc_pkg::*;
    logic            clock, srst, cmd_wr, cmd_rd, cmd_page;
    logic [7:0]      cmd_code;
    logic [15:0]     cmd_wdata, rd_data_r;
    logic            rd_valid_r, cml_fault_r;
    logic [1:0]      run_tb, op_on, power_good_signal, stuck;
    logic [1:0]      vout_above_uv, vout_below_eighth, run_pin_o;
    logic [1:0]      run_pin_oe_n, scope_trig_r, oc_fault_r, oc_warn_r;
    logic [1:0]      ramping_r, regulating_r, ton_fault_r, toff_warn_r;
    logic [1:0][15:0] sense_diff_mv, iout_avg_a, slew_rate_r;
    logic [1:0][7:0] serial_offset_code;
    logic [1:0][1:0] emulated_load_step_r;
    wire  [1:0]      run_pin_i;
    wire  [6:0]      ev;
    int              miscompares, n_tests, i, k;
    logic [7:0]      codes [12] = '{CMD_SLEW, CMD_GAIN, CMD_OCF, CMD_OCW,
        CMD_TOND, CMD_TONR, CMD_TONM, CMD_TOFD, CMD_TOFF, CMD_TOFW,
        CMD_RST, CMD_EMU};
    logic [15:0]     rvs [12] = '{RV_SLEW, RV_GAIN, RV_OCF, RV_OCW, RV_TOND,
        RV_TONR, RV_TONM, RV_TOFD, RV_TOFF, RV_TOFW, RV_RST, 16'h0000};
    // Pin level resolved from the device's low drive and the pull-up side
    assign run_pin_i = (run_pin_oe_n & run_tb) | (~run_pin_oe_n & run_pin_o);
    assign ev = {toff_warn_r[1], emulated_load_step_r[1] == 2'b10,
        scope_trig_r[0], ton_fault_r[1], run_pin_oe_n[0], regulating_r[0],
        ramping_r[0]};
    clsc_bank #(.MS_CYCLES(10), .LSE_PULSE(5)) dut (.clock, .srst, .cmd_wr,
        .cmd_rd, .cmd_page, .cmd_code, .cmd_wdata, .rd_data_r, .rd_valid_r,
        .cml_fault_r, .run_pin_i, .op_on, .power_good_signal, .sense_diff_mv,
        .iout_avg_a, .vout_above_uv, .vout_below_eighth, .serial_offset_code,
        .run_pin_o, .run_pin_oe_n, .emulated_load_step_r, .scope_trig_r,
        .oc_fault_r, .oc_warn_r, .ramping_r, .regulating_r, .ton_fault_r,
        .toff_warn_r, .slew_rate_r);
    clsc_stage_model stage (.clock, .ramping(ramping_r),
        .regulating(regulating_r), .stuck, .above_uv(vout_above_uv),
        .below_eighth(vout_below_eighth), .power_good(power_good_signal));
    initial begin
        clock = 0;
        forever #2 clock = ~clock;
    end
    task automatic results();
        if (miscompares == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic rng(input int v, input int lo, input int hi);
        chk(16'(v >= lo && v <= hi), 16'h0001);
    endtask : rng
    task automatic wr(input logic p, input logic [7:0] c, input logic [15:0] d);
        // Idle edge first: a strobe never drops and rises in one step
        @(negedge clock);
        {cmd_wr, cmd_page, cmd_code, cmd_wdata} = {1'b1, p, c, d};
        @(negedge clock);
        cmd_wr = 0;
    endtask : wr
    task automatic rd(input logic p, input logic [7:0] c, input logic [15:0] e);
        @(negedge clock);
        {cmd_rd, cmd_page, cmd_code} = {1'b1, p, c};
        @(negedge clock);
        cmd_rd = 0;
        chk(rd_valid_r === 1'b1 ? rd_data_r : ~e, e);
    endtask : rd
    // Bounded wait for one event bit; k returns the cycles spent
    task automatic wev(input int b, input logic v, input int n, output int k);
        for (k = 0; k < n && ev[b] !== v; k++)
            @(negedge clock);
        if (k == n) begin
            miscompares++;
            results();
        end
    endtask : wev
    initial begin
        {cmd_wr, cmd_rd, cmd_page, cmd_code, cmd_wdata} = '0;
        {run_tb, op_on, stuck, sense_diff_mv, iout_avg_a} = '0;
        serial_offset_code = {8'h5a, 8'ha5};
        srst = 1;
        repeat (2) @(negedge clock);
        srst = 0;
        for (i = 0; i < 12; i++)
            rd(0, codes[i], rvs[i]);
        rd(1, CMD_SPI, 16'h005a);
        wr(0, CMD_SPI, 16'h0001);
        chk(cml_fault_r, 1);
        for (i = 0; i < 4; i++) begin
            wr(1, CMD_EMU, 16'h00f0 | 16'(i));
            chk(16'(emulated_load_step_r), 16'(i) << 2);
        end
        rd(1, CMD_EMU, 16'h0003);
        wr(1, CMD_EMU, 16'h0006);
        wev(5, 0, 20, k);
        chk(16'(k), 16'd5);
        wr(1, CMD_SLEW, 16'h1234);
        chk(slew_rate_r[1], 16'h1234);
        wr(1, CMD_GAIN, 16'hca90);
        chk(cml_fault_r, 0);
        wr(0, CMD_TOND, 16'h0002);
        wr(0, CMD_RST, 16'h0001);
        wr(0, CMD_EMU, 16'h000e);
        sense_diff_mv[0] = 16'd200;
        iout_avg_a[0] = 16'd25;
        {run_tb, op_on} = 4'b0101;
        wev(0, 1, 100, k);
        rng(k, 22, 31);
        // Warning flop lags the ramp flag by one cycle
        @(negedge clock);
        chk({oc_fault_r[0], oc_warn_r[0]}, 0);
        wev(1, 1, 200, k);
        rng(k, 80, 89);
        wr(0, CMD_GAIN, 16'h0000);
        chk(cml_fault_r, 1);
        chk({oc_fault_r[0], oc_warn_r[0]}, 3);
        rd(0, CMD_GAIN, RV_GAIN);
        run_tb[0] = 0;
        wev(4, 1, 20, k);
        chk({run_pin_oe_n[0], run_pin_o[0]}, 0);
        run_tb[0] = 1;
        wev(2, 1, 2000, k);
        rng(k, 1439, 1448);
        {stuck, run_tb[1], op_on[1]} = 4'b1011;
        wev(3, 1, 200, k);
        rng(k, 112, 121);
        wr(1, CMD_TOFW, 16'h0078);
        op_on[1] = 0;
        wev(6, 1, 1400, k);
        rng(k, 1302, 1311);
        results();
    end
endmodule : clsc_bank_tb
